/* File: hw/scr_card_regs.sv */
`default_nettype none
`include "scr_defines.svh"

module scr_card_regs
  import scr_pkg::*;
#(
  parameter logic [3:0] SILICON_REV = 4'h1 // Arbitrary value
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Byte access by index
  input wire logic wr_i,
  input wire logic [7:0] idx_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  // Live socket interface state
  input wire logic [7:0] interface_status_i
);

  logic [7:0] regs_reg [`SCR_CARD_NREG];
  logic [7:0] id_byte;
  logic idx_ok;
  logic wr_ok;

  // Fixed type code, undescribed bits zero, revision in the low nibble
  assign id_byte = {`SCR_ID_TYPE, 2'h0, SILICON_REV};
  assign idx_ok = scr_idx_valid(idx_i);
  // Identification and interface status are read-only
  assign wr_ok = wr_i && idx_ok && (idx_i != `SCR_ID_IDX) && (idx_i != `SCR_INTERFACE_STATUS_IDX);

  // Read mux; reserved slots read zero
  assign rdata_o = !idx_ok ? 8'h00 :
                   (idx_i == `SCR_ID_IDX) ? id_byte :
                   (idx_i == `SCR_INTERFACE_STATUS_IDX) ? interface_status_i :
                   regs_reg[idx_i[5:0]];

  // Plain read/write storage for the other card registers
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < `SCR_CARD_NREG; i++) begin
        regs_reg[i] <= 8'h00;
      end
    end else if (wr_ok) begin
      regs_reg[idx_i[5:0]] <= wdata_i;
    end
  end

endmodule : scr_card_regs

`default_nettype wire

/* File: hw/scr_defines.svh */
`ifndef SCR_DEFINES_SVH
`define SCR_DEFINES_SVH

// Access spaces of the shared access port
`define SCR_SP_CFG 2'h0
`define SCR_SP_IO 2'h1
`define SCR_SP_MEM 2'h2

// Configuration space
`define SCR_CTRL_OFF 8'h93
`define SCR_DEVICE_CONTROL_RST 8'h60
`define SCR_DEVICE_CONTROL_FIXED 8'h60
`define SCR_DEVICE_CONTROL_MODE_MSB 2
`define SCR_DEVICE_CONTROL_MODE_LSB 1
`define SCR_FIFOCTL_RST 8'h00
`define SCR_FIFOCTL_MASK 8'h0F
`define SCR_FUNC_DEVICE_CONTROL 1'h0
`define SCR_FUNC_FIFOCTL 1'h1

// Interrupt mode codes and card control enable position
`define SCR_IRQ_MODE_NONE 2'h0
`define SCR_IRQ_MODE_ISA 2'h1
`define SCR_CARD_IEN_BIT 5

// Legacy index/data port offsets
`define SCR_IO_INDEX_OFF 2'h0
`define SCR_IO_DATA_OFF 2'h1

// Memory window: card index n sits at 800h + n
`define SCR_MEM_WIN_HI 4'h8
`define SCR_CARD_LAST_IDX 8'h37
`define SCR_CARD_NREG 56

// Card register indices and values
`define SCR_ID_IDX 8'h00
`define SCR_INTERFACE_STATUS_IDX 8'h01
`define SCR_ID_TYPE 2'h2
`define SCR_ID_RST 8'h80

`endif

/* File: hw/scr_pkg.sv */
`default_nettype none
`include "scr_defines.svh"

package scr_pkg;

  // One register access on the shared access port
  typedef struct packed {
    logic rd;
    logic wr;
    logic [1:0] space;
    logic func;
    logic [31:0] addr;
    logic [7:0] wdata;
  } scr_acc_s;

  // Single-transfer limits per FIFO direction
  typedef struct packed {
    logic cb_read;
    logic cb_write;
    logic pci_read;
    logic pci_write;
  } scr_fifo_lim_s;

  // Reserved slots and indices past the map hold no register
  // Each group fills from its lowest index, so the spare slots sit at the top of a group
  function automatic logic scr_idx_valid(input logic [7:0] idx);
    logic res;
    res = (idx == 8'h17) || (idx == 8'h1F) || (idx == 8'h26) || (idx == 8'h27) ||
          (idx == 8'h2E) || (idx == 8'h2F) || (idx == 8'h36) || (idx == 8'h37);
    return !res && (idx <= `SCR_CARD_LAST_IDX);
  endfunction : scr_idx_valid

endpackage : scr_pkg

`default_nettype wire

/* File: hw/scr_socket_config_regs.sv */
`default_nettype none
`include "scr_defines.svh"

module scr_socket_config_regs
  import scr_pkg::*;
#(
  parameter logic [3:0] SILICON_REV = 4'h1 // Arbitrary value
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Register access port
  input wire scr_acc_s acc_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output logic wack_o,
  output logic io_err_o,
  // Window bases set elsewhere in configuration space
  input wire logic [31:0] legacy_index_port_base_i,
  input wire logic [31:0] socket_status_mem_base_i,
  // Card control byte and socket state
  input wire logic [7:0] card_control_i,
  input wire logic [7:0] interface_status_i,
  // Interrupt request from the card and delivered interrupts
  input wire logic card_irq_req_i,
  output logic isa_irq_o,
  output logic pci_int_o,
  // Transfer request classification from the datapath
  input wire logic [1:0] xfer_dir_i,
  input wire logic xfer_cfg_io_i,
  output logic xfer_single_o,
  // Programmed limits and mode
  output scr_fifo_lim_s fifo_lim_o,
  output logic [1:0] irq_mode_o
);

  // Reset images, split by field so no reset assignment truncates
  localparam logic [7:0] DEVICE_CONTROL_RST = `SCR_DEVICE_CONTROL_RST;
  localparam logic [7:0] FIFOCTL_RST = `SCR_FIFOCTL_RST & `SCR_FIFOCTL_MASK;

  // Control state
  logic [1:0] irq_mode_reg;
  logic [1:0] irq_mode_next;
  logic [3:0] fifo_ctl_reg;
  logic [3:0] fifo_ctl_next;
  logic [7:0] index_reg;
  logic [7:0] index_next;

  // Answer state
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic wack_reg;
  logic io_err_reg;
  logic isa_irq_reg;
  logic pci_int_reg;
  logic xfer_single_reg;

  // Decode wires
  logic acc_any;
  logic sp_cfg;
  logic sp_io;
  logic sp_mem;
  logic cfg_hit;
  logic device_control_hit;
  logic fifoctl_hit;
  logic io_win;
  logic io_index_hit;
  logic io_data_hit;
  logic io_bad;
  logic mem_win;
  logic mem_hit;
  logic card_sel;
  logic card_wr;
  logic [7:0] card_idx;
  logic [7:0] card_rdata;
  logic [7:0] device_control_rd;
  logic [7:0] fifoctl_rd;
  logic int_en;
  logic mode_isa;
  logic lim_sel;

  // Space selection
  assign acc_any = acc_i.rd || acc_i.wr;
  assign sp_cfg = acc_any && (acc_i.space == `SCR_SP_CFG);
  assign sp_io = acc_any && (acc_i.space == `SCR_SP_IO);
  assign sp_mem = acc_any && (acc_i.space == `SCR_SP_MEM);

  // Both control bytes share one offset; the function number picks one
  assign cfg_hit = sp_cfg && (acc_i.addr[7:0] == `SCR_CTRL_OFF);
  assign device_control_hit = cfg_hit && (acc_i.func == `SCR_FUNC_DEVICE_CONTROL);
  assign fifoctl_hit = cfg_hit && (acc_i.func == `SCR_FUNC_FIFOCTL);

  // Legacy port pair occupies one double word at the base
  assign io_win = sp_io && (acc_i.addr[31:2] == legacy_index_port_base_i[31:2]);
  assign io_index_hit = io_win && (acc_i.addr[1:0] == `SCR_IO_INDEX_OFF);
  assign io_data_hit = io_win && (acc_i.addr[1:0] == `SCR_IO_DATA_OFF);
  assign io_bad = io_win && !io_index_hit && !io_data_hit;

  // Memory window: the 256 bytes at 800h of the 4 KB page named by the base
  assign mem_win = sp_mem && (acc_i.addr[31:12] == socket_status_mem_base_i[31:12]) &&
                   (acc_i.addr[11:8] == `SCR_MEM_WIN_HI);
  assign mem_hit = mem_win && scr_idx_valid(acc_i.addr[7:0]);

  // Card register selection, index from port or window offset
  assign card_idx = io_data_hit ? index_reg : acc_i.addr[7:0];
  assign card_sel = io_data_hit || mem_hit;
  assign card_wr = card_sel && acc_i.wr;

  // Read images of the two control bytes
  assign device_control_rd = `SCR_DEVICE_CONTROL_FIXED | {5'h00, irq_mode_reg, 1'b0};
  assign fifoctl_rd = {4'h0, fifo_ctl_reg};

  // Next values of the writable fields
  assign irq_mode_next = (device_control_hit && acc_i.wr) ?
    acc_i.wdata[`SCR_DEVICE_CONTROL_MODE_MSB:`SCR_DEVICE_CONTROL_MODE_LSB] : irq_mode_reg;
  assign fifo_ctl_next = (fifoctl_hit && acc_i.wr) ?
    acc_i.wdata[3:0] : fifo_ctl_reg;
  assign index_next = (io_index_hit && acc_i.wr) ? acc_i.wdata : index_reg;

  // Read answer; unmapped addresses read zero
  assign rdata_next = device_control_hit ? device_control_rd :
                      fifoctl_hit ? fifoctl_rd :
                      io_index_hit ? index_reg :
                      card_sel ? card_rdata :
                      8'h00;

  // Control registers, written only on a hit
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_mode_reg <= DEVICE_CONTROL_RST[`SCR_DEVICE_CONTROL_MODE_MSB:`SCR_DEVICE_CONTROL_MODE_LSB];
      fifo_ctl_reg <= FIFOCTL_RST[3:0];
      index_reg <= 8'h00;
    end else begin
      irq_mode_reg <= irq_mode_next;
      fifo_ctl_reg <= fifo_ctl_next;
      index_reg <= index_next;
    end
  end

  // Access answers, one cycle after the request
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
      wack_reg <= 1'b0;
      io_err_reg <= 1'b0;
    end else begin
      rdata_reg <= acc_i.rd ? rdata_next : rdata_reg;
      rvalid_reg <= acc_i.rd;
      wack_reg <= acc_i.wr;
      io_err_reg <= io_bad;
    end
  end

  // Interrupt gating: card control bit 5 is the master switch
  assign int_en = card_control_i[`SCR_CARD_IEN_BIT];
  // Reserved mode codes behave like no interrupts
  assign mode_isa = int_en && (irq_mode_reg == `SCR_IRQ_MODE_ISA);

  // Registered so the interrupt pins never glitch on a mode write
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      isa_irq_reg <= 1'b0;
      pci_int_reg <= 1'b0;
    end else begin
      isa_irq_reg <= mode_isa && card_irq_req_i;
      pci_int_reg <= mode_isa && card_irq_req_i;
    end
  end

  // Per-direction limit for the current transfer request
  always_comb begin
    case (xfer_dir_i)
      2'h0: lim_sel = fifo_ctl_reg[0];
      2'h1: lim_sel = fifo_ctl_reg[1];
      2'h2: lim_sel = fifo_ctl_reg[2];
      2'h3: lim_sel = fifo_ctl_reg[3];
      default: lim_sel = 1'b0;
    endcase
  end

  // Command transfers always run at full depth
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      xfer_single_reg <= 1'b0;
    end else begin
      xfer_single_reg <= lim_sel && !xfer_cfg_io_i;
    end
  end

  // Card register set behind both windows
  scr_card_regs #(
    .SILICON_REV(SILICON_REV)
  ) u_card_regs (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .wr_i(card_wr),
    .idx_i(card_idx),
    .wdata_i(acc_i.wdata),
    .rdata_o(card_rdata),
    .interface_status_i(interface_status_i)
  );

  // Outputs
  assign rdata_o = rdata_reg;
  assign rvalid_o = rvalid_reg;
  assign wack_o = wack_reg;
  assign io_err_o = io_err_reg;
  assign isa_irq_o = isa_irq_reg;
  assign pci_int_o = pci_int_reg;
  assign xfer_single_o = xfer_single_reg;
  assign irq_mode_o = irq_mode_reg;
  assign fifo_lim_o = {fifo_ctl_reg[3], fifo_ctl_reg[2],
                       fifo_ctl_reg[1], fifo_ctl_reg[0]};

endmodule : scr_socket_config_regs

`default_nettype wire

/* File: tb/scr_cfg_monitor.sv */
`default_nettype none

module scr_cfg_monitor
  import scr_pkg::*;
#(
  parameter logic [3:0] SILICON_REV = 4'h1
) (
  // Clock, reset and access port
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire scr_acc_s acc_i,
  input wire logic [7:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic io_err_o,
  input wire logic [31:0] legacy_index_port_base_i,
  input wire logic [31:0] socket_status_mem_base_i,
  // Interrupt and transfer side
  input wire logic [7:0] card_control_i,
  input wire logic card_irq_req_i,
  input wire logic isa_irq_o,
  input wire logic pci_int_o,
  input wire logic [1:0] xfer_dir_i,
  input wire logic xfer_cfg_io_i,
  input wire logic xfer_single_o,
  input wire scr_fifo_lim_s fifo_lim_o,
  input wire logic [1:0] irq_mode_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  // Access steps: reads answered on the next edge, and any access to an upper legacy port
  sequence cfg_rd_s(f);
    acc_i.rd && acc_i.space == 2'h0 && acc_i.addr == 32'h93 && acc_i.func == f ##1 rvalid_o;
  endsequence
  sequence id_rd_s;
    acc_i.rd && acc_i.space == 2'h2 && acc_i.addr == (socket_status_mem_base_i[31:12] << 12
      | 32'h800) ##1 rvalid_o;
  endsequence
  sequence io_hi_s;
    (acc_i.rd || acc_i.wr) && acc_i.space == 2'h1 && acc_i.addr[1]
      && acc_i.addr[31:2] == legacy_index_port_base_i[31:2];
  endsequence

  // Fixed bits must survive any write, so tie them to the live mode
  rd_answer_a: assert property (acc_i.rd |=> rvalid_o)
    else $error("read not answered");
  dev_fixed_a: assert property (
    cfg_rd_s(1'b0) |-> rdata_o == {3'h3, 2'h0, irq_mode_o, 1'b0})
    else $error("device control read wrong");
  fifo_read_a: assert property (cfg_rd_s(1'b1) |-> rdata_o == {4'h0, fifo_lim_o})
    else $error("buffer control read wrong");
  id_byte_a: assert property (id_rd_s |-> rdata_o == {4'h8, SILICON_REV})
    else $error("identification byte wrong");
  isa_gate_a: assert property (
    isa_irq_o == $past(card_control_i[5] && irq_mode_o == 2'h1 && card_irq_req_i))
    else $error("isa interrupt wrong");
  pci_gate_a: assert property (
    pci_int_o == $past(card_control_i[5] && irq_mode_o == 2'h1 && card_irq_req_i))
    else $error("pci interrupt wrong");
  xfer_limit_a: assert property (
    xfer_single_o == $past(!xfer_cfg_io_i && fifo_lim_o[xfer_dir_i]))
    else $error("single transfer limit wrong");
  cmd_free_a: assert property (xfer_cfg_io_i |=> !xfer_single_o)
    else $error("command limited");
  port_err_a: assert property (io_hi_s |=> io_err_o)
    else $error("upper port not flagged");
endmodule : scr_cfg_monitor

bind scr_socket_config_regs scr_cfg_monitor #(.SILICON_REV(SILICON_REV)) mon (
  .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .acc_i(acc_i), .rdata_o(rdata_o),
  .rvalid_o(rvalid_o), .io_err_o(io_err_o), .legacy_index_port_base_i(legacy_index_port_base_i),
  .socket_status_mem_base_i(socket_status_mem_base_i), .card_control_i(card_control_i),
  .card_irq_req_i(card_irq_req_i), .isa_irq_o(isa_irq_o), .pci_int_o(pci_int_o),
  .xfer_dir_i(xfer_dir_i), .xfer_cfg_io_i(xfer_cfg_io_i), .xfer_single_o(xfer_single_o),
  .fifo_lim_o(fifo_lim_o), .irq_mode_o(irq_mode_o));

`default_nettype wire

/* File: tb/testbench.sv */
`default_nettype none
`include "scr_defines.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import scr_pkg::*;
  localparam logic [3:0] REV = 4'h5; // Arbitrary revision
  localparam logic [31:0] IOB = 32'h0000_03E0;
  localparam logic [31:0] MB = 32'hFEDC_B000;
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  scr_acc_s acc = '0;
  logic [7:0] rdata;
  logic [7:0] cctl = 8'h00;
  logic rvalid, wack, ioerr, isa, pci, single;
  logic req = 1'b0;
  logic cfgio = 1'b0;
  logic [1:0] dir = 2'h0;
  logic [1:0] mode;
  scr_fifo_lim_s lim;
  int n_errors = 0;
  int check_count = 0;

  // Free running 50 MHz clock
  always #10 ref_clk_i = ~ref_clk_i;

  scr_socket_config_regs #(.SILICON_REV(REV)) uut (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .acc_i(acc), .rdata_o(rdata),
    .rvalid_o(rvalid), .wack_o(wack), .io_err_o(ioerr), .legacy_index_port_base_i(IOB),
    .socket_status_mem_base_i(MB), .card_control_i(cctl), .interface_status_i(8'h3C),
    .card_irq_req_i(req), .isa_irq_o(isa), .pci_int_o(pci), .xfer_dir_i(dir),
    .xfer_cfg_io_i(cfgio), .xfer_single_o(single), .fifo_lim_o(lim), .irq_mode_o(mode));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One access, answer sampled one edge later
  task automatic xfer(input logic r, input logic [1:0] sp, input logic f, input logic [31:0] a,
                      input logic [7:0] d);
    @(posedge ref_clk_i);
    acc <= '{rd: r, wr: !r, space: sp, func: f, addr: a, wdata: d};
    @(posedge ref_clk_i);
    acc <= '0;
    #1;
    check("answer", {7'h0, r ? rvalid : wack}, 8'h01);
  endtask : xfer

  task automatic rd_chk(input logic [1:0] sp, input logic f, input logic [31:0] a,
                        input logic [7:0] exp);
    xfer(1'b1, sp, f, a, 8'h00);
    check("read data", rdata, exp);
  endtask : rd_chk

  task automatic t_reset;
    rd_chk(`SCR_SP_CFG, 1'b0, 32'h93, 8'h60);
    rd_chk(`SCR_SP_CFG, 1'b1, 32'h93, 8'h00);
    rd_chk(`SCR_SP_MEM, 1'b0, MB | 32'h800, {4'h8, REV});
  endtask : t_reset

  task automatic t_device_control;
    xfer(1'b0, `SCR_SP_CFG, 1'b0, 32'h93, 8'hFF);
    rd_chk(`SCR_SP_CFG, 1'b0, 32'h93, 8'h66);
    xfer(1'b0, `SCR_SP_CFG, 1'b0, 32'h93, 8'h00);
    rd_chk(`SCR_SP_CFG, 1'b0, 32'h93, 8'h60);
  endtask : t_device_control

  // Each limit bit alone, every direction, with and without a command
  task automatic t_fifo;
    for (int i = 0; i < 4; i++) begin
      xfer(1'b0, `SCR_SP_CFG, 1'b1, 32'h93, 8'hF0 | (8'h01 << i));
      rd_chk(`SCR_SP_CFG, 1'b1, 32'h93, 8'h01 << i);
      check("limits", {4'h0, lim}, 8'h01 << i);
      for (int d = 0; d < 4; d++) begin
        @(posedge ref_clk_i);
        dir <= d[1:0];
        cfgio <= 1'b0;
        @(posedge ref_clk_i);
        cfgio <= 1'b1;
        #1;
        check("single", {7'h0, single}, {7'h0, d == i});
        @(posedge ref_clk_i);
        #1;
        check("command single", {7'h0, single}, 8'h00);
      end
    end
    @(posedge ref_clk_i);
    cfgio <= 1'b0;
  endtask : t_fifo

  // Every mode code with the enable off and on
  task automatic t_irq;
    for (int e = 0; e < 2; e++) begin
      for (int m = 0; m < 4; m++) begin
        xfer(1'b0, `SCR_SP_CFG, 1'b0, 32'h93, {5'h0, m[1:0], 1'b0});
        check("mode", {6'h0, mode}, m[7:0]);
        @(posedge ref_clk_i);
        cctl <= (e != 0) ? 8'h20 : 8'h00;
        req <= 1'b1;
        @(posedge ref_clk_i);
        @(posedge ref_clk_i);
        #1;
        check("isa irq", {7'h0, isa}, {7'h0, e != 0 && m == 1});
        check("pci irq", {7'h0, pci}, {7'h0, e != 0 && m == 1});
      end
    end
    // Enabled ISA mode but no request from the card: both pins stay low
    xfer(1'b0, `SCR_SP_CFG, 1'b0, 32'h93, 8'h02);
    @(posedge ref_clk_i);
    req <= 1'b0;
    @(posedge ref_clk_i);
    @(posedge ref_clk_i);
    #1;
    check("isa idle", {7'h0, isa}, 8'h00);
    check("pci idle", {7'h0, pci}, 8'h00);
  endtask : t_irq

  // Index/data ports and memory window reach the same storage
  task automatic t_io;
    xfer(1'b0, `SCR_SP_IO, 1'b0, IOB, 8'h02);
    xfer(1'b0, `SCR_SP_IO, 1'b0, IOB + 32'h1, 8'hA5);
    rd_chk(`SCR_SP_MEM, 1'b0, MB | 32'h802, 8'hA5);
    rd_chk(`SCR_SP_IO, 1'b0, IOB, 8'h02);
    xfer(1'b0, `SCR_SP_MEM, 1'b0, MB | 32'h835, 8'h5A);
    xfer(1'b0, `SCR_SP_IO, 1'b0, IOB, 8'h35);
    rd_chk(`SCR_SP_IO, 1'b0, IOB + 32'h1, 8'h5A);
    xfer(1'b0, `SCR_SP_MEM, 1'b0, MB | 32'h800, 8'h3F);
    rd_chk(`SCR_SP_MEM, 1'b0, MB | 32'h800, {4'h8, REV});
    xfer(1'b0, `SCR_SP_MEM, 1'b0, MB | 32'h817, 8'hFF);
    rd_chk(`SCR_SP_MEM, 1'b0, MB | 32'h817, 8'h00);
    rd_chk(`SCR_SP_MEM, 1'b0, MB | 32'h801, 8'h3C);
    rd_chk(`SCR_SP_MEM, 1'b0, MB | 32'h838, 8'h00);
    rd_chk(`SCR_SP_MEM, 1'b0, (MB + 32'h1000) | 32'h802, 8'h00);
    xfer(1'b1, `SCR_SP_IO, 1'b0, IOB + 32'h2, 8'h00);
    check("io error", {7'h0, ioerr}, 8'h01);
  endtask : t_io

  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  // Main sequence after an 8 cycle reset
  initial begin
    repeat (8) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    t_reset();
    t_device_control();
    t_fifo();
    t_irq();
    t_io();
    print_verdict();
  end

  // Hang guard
  initial begin
    #1000000;
    n_errors++;
    print_verdict();
  end
endmodule : testbench

`default_nettype wire
